// ==== sim/sebs_bus_master.sv ====
`timescale 1ns/100ps
module sebs_bus_master
   import sebs_pkg::*;
(
   // Timing reference
   input  wire logic linkClk,
   // Bus lines
   output logic      sclDrv,
   output logic      sdaDrv,
   input  wire logic sdaLine
);
   // Idle bus, clock stands still high
   initial
   begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
   end

   // Keeps SDA edges clear of SCL edges
   task automatic gap();
      repeat (4) @(posedge linkClk);
      #1;
   endtask

   task automatic halfBit();
      repeat (12) @(posedge linkClk);
      #1;
   endtask

   task automatic start();
      gap();
      sdaDrv = 1'b1;
      halfBit();
      sclDrv = 1'b1;
      halfBit();
      sdaDrv = 1'b0;
      halfBit();
      sclDrv = 1'b0;
   endtask

   task automatic stop();
      gap();
      sdaDrv = 1'b0;
      halfBit();
      sclDrv = 1'b1;
      halfBit();
      sdaDrv = 1'b1;
      halfBit();
   endtask

   // Data set while SCL low, sampled at end of high phase
   task automatic bitIo(input logic b, output logic r);
      gap();
      sdaDrv = b;
      halfBit();
      sclDrv = 1'b1;
      halfBit();
      r = sdaLine;
      sclDrv = 1'b0;
   endtask

   task automatic sendByte(input sebs_byte_t b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitIo(b[i], r);
      bitIo(1'b1, r);
      ack = ~r;
   endtask

   task automatic recvByte(input logic mAck, output sebs_byte_t b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitIo(1'b1, r);
         b[i] = r;
      end
      bitIo(~mAck, r);
   endtask

   // Nine clocks with SDA released, then a start
   task automatic recover();
      logic r;
      for (int i = 0; i < 9; i++)
         bitIo(1'b1, r);
      start();
   endtask
endmodule

// ==== sim/sebs_top_sva.sv ====
`timescale 1ns/100ps
module sebs_top_sva
   import sebs_pkg::*;
#(
   parameter int unsigned PROG_CYC = 50,
   parameter int unsigned FILT_LEN = 3
)
(
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic linkClk,
   // Bus
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOeN,
   // Pins
   input wire logic strap_addr_bit0,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic wpIn,
   input wire logic nvClear,
   // Status
   input wire logic standby,
   input wire logic progBusy,
   input wire logic nvLocked
);
   logic [31:0] busyCnt_q;

   // Length of the current busy stretch
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         busyCnt_q <= '0;
      else if (progBusy)
         busyCnt_q <= busyCnt_q + 32'h1;
      else
         busyCnt_q <= '0;
   end

   sequence s_ackLow;
      (!sdaOeN)[*8];
   endsequence

   sequence s_released;
      sdaOeN[*8];
   endsequence

   property p_neverHigh;
      @(posedge linkClk) disable iff (sys_rst) sdaOut == 1'b0;
   endproperty
   a_neverHigh: assert property (p_neverHigh)
      else $error("sda driven high");

   property p_quietAfterReset;
      @(posedge linkClk) disable iff (sys_rst) $fell(sys_rst) |-> s_released;
   endproperty
   a_quietAfterReset: assert property (p_quietAfterReset)
      else $error("sda pulled without start");

   property p_changeSclLow;
      @(posedge linkClk) disable iff (sys_rst) $changed(sdaOeN) |-> !sclIn;
   endproperty
   a_changeSclLow: assert property (p_changeSclLow)
      else $error("sda changed while scl high");

   property p_ackHolds;
      @(posedge linkClk) disable iff (sys_rst) $fell(sdaOeN) |-> s_ackLow;
   endproperty
   a_ackHolds: assert property (p_ackHolds)
      else $error("low level too short");

   property p_noAckBusy;
      @(posedge linkClk) disable iff (sys_rst) $fell(sdaOeN) |-> !progBusy;
   endproperty
   a_noAckBusy: assert property (p_noAckBusy)
      else $error("answered while programming");

   property p_progLen;
      @(posedge clk_sys) disable iff (sys_rst) $fell(progBusy) |-> busyCnt_q == PROG_CYC;
   endproperty
   a_progLen: assert property (p_progLen)
      else $error("programming length wrong");

   property p_busyBound;
      @(posedge clk_sys) disable iff (sys_rst) busyCnt_q <= PROG_CYC;
   endproperty
   a_busyBound: assert property (p_busyBound)
      else $error("programming overran");

   property p_standbyAfterProg;
      @(posedge linkClk) disable iff (sys_rst) $fell(progBusy) |-> ##[1:12] standby;
   endproperty
   a_standbyAfterProg: assert property (p_standbyAfterProg)
      else $error("no standby after programming");

   property p_wake;
      @(posedge linkClk) disable iff (sys_rst) $fell(sclIn) |-> ##[1:10] !standby;
   endproperty
   a_wake: assert property (p_wake)
      else $error("standby kept during activity");

   property p_lockSticky;
      @(posedge linkClk) disable iff (sys_rst) $rose(nvLocked) |=> nvLocked[*8];
   endproperty
   a_lockSticky: assert property (p_lockSticky)
      else $error("lock dropped");
endmodule

bind sebs_top sebs_top_sva #(
   .PROG_CYC(PROG_CYC),
   .FILT_LEN(FILT_LEN)
) u_sebs_top_sva (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOeN(sdaOeN), .strap_addr_bit0(strap_addr_bit0),
   .strap_addr_bit1(strap_addr_bit1), .strap_addr_bit2(strap_addr_bit2), .wpIn(wpIn),
   .nvClear(nvClear), .standby(standby), .progBusy(progBusy), .nvLocked(nvLocked)
);

// ==== sim/sebs_top_tb.sv ====
`timescale 1ns/100ps
`include "sebs_regs.svh"
module sebs_top_tb
   import sebs_pkg::*;
   ;
   localparam int unsigned PROG = 400;
   logic       clk_sys;
   logic       sys_rst;
   logic       linkClk;
   logic       sclDrv;
   logic       mstSda;
   logic       sdaLine;
   logic       sdaOut;
   logic       sdaOeN;
   logic       standby;
   logic       progBusy;
   logic       nvLocked;
   sebs_pins_s pins;
   int         n_fail;
   int         n_checks;

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   initial linkClk = 1'b0;
   always #16 linkClk = ~linkClk;

   // Open-drain wire with pull-up
   assign sdaLine = mstSda & (sdaOeN | sdaOut);

   sebs_top #(
      .PROG_CYC(PROG)
   ) u_sebs_top (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk), .sclIn(sclDrv),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .strap_addr_bit0(pins.strap[0]),
      .strap_addr_bit1(pins.strap[1]), .strap_addr_bit2(pins.strap[2]), .wpIn(pins.wp),
      .nvClear(pins.clr), .standby(standby), .progBusy(progBusy), .nvLocked(nvLocked)
   );

   sebs_bus_master u_sebs_bus_master (
      .linkClk(linkClk), .sclDrv(sclDrv), .sdaDrv(mstSda), .sdaLine(sdaLine)
   );

   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input sebs_byte_t seen, input sebs_byte_t exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   function automatic sebs_byte_t dev(input logic [3:0] kind, input logic rw);
      return {kind, pins.strap, rw};
   endfunction

   task automatic xfer(input string what, input sebs_byte_t b, input logic expAck);
      logic ack;
      u_sebs_bus_master.sendByte(b, ack);
      chk(what, {7'h0, ack}, {7'h0, expAck});
   endtask

   // Busy seen or not, poll while busy, standby afterwards
   task automatic waitProg(input logic expBusy);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 40 && !seen; i++)
      begin
         tick(1);
         seen = (progBusy === 1'b1);
      end
      chk("busy", {7'h0, seen}, {7'h0, expBusy});
      if (seen)
      begin
         u_sebs_bus_master.start();
         xfer("poll", dev(`SEBS_TYPE_MEM, 1'b0), 1'b0);
         u_sebs_bus_master.stop();
         for (int i = 0; i < 800 && progBusy !== 1'b0; i++)
            tick(1);
      end
      tick(6);
      chk("standby", {7'h0, standby}, 8'h01);
   endtask

   task automatic writeAt(input sebs_byte_t a, input sebs_byte_t d, input logic ok);
      u_sebs_bus_master.start();
      xfer("devW", dev(`SEBS_TYPE_MEM, 1'b0), 1'b1);
      xfer("word", a, 1'b1);
      xfer("data", d, ok);
      u_sebs_bus_master.stop();
      waitProg(ok);
   endtask

   task automatic readAt(input sebs_byte_t a, input sebs_byte_t e0, input sebs_byte_t e1);
      sebs_byte_t b;
      u_sebs_bus_master.start();
      xfer("devW", dev(`SEBS_TYPE_MEM, 1'b0), 1'b1);
      xfer("word", a, 1'b1);
      u_sebs_bus_master.start();
      xfer("devR", dev(`SEBS_TYPE_MEM, 1'b1), 1'b1);
      u_sebs_bus_master.recvByte(1'b1, b);
      chk("rd0", b, e0);
      u_sebs_bus_master.recvByte(1'b0, b);
      chk("rd1", b, e1);
      u_sebs_bus_master.stop();
      tick(20);
   endtask

   task automatic s_decode();
      for (int s = 0; s < 8; s++)
      begin
         pins.strap = 3'(s);
         tick(4);
         u_sebs_bus_master.start();
         xfer("match", dev(`SEBS_TYPE_MEM, 1'b0), 1'b1);
         u_sebs_bus_master.start();
         xfer("miss", dev(`SEBS_TYPE_MEM, 1'b0) ^ 8'h02, 1'b0);
         u_sebs_bus_master.start();
         xfer("type", dev(4'h5, 1'b0), 1'b0);
         u_sebs_bus_master.stop();
         tick(10);
      end
   endtask

   task automatic s_page();
      u_sebs_bus_master.start();
      xfer("devW", dev(`SEBS_TYPE_MEM, 1'b0), 1'b1);
      xfer("word", 8'h0e, 1'b1);
      for (int i = 1; i <= 3; i++)
         xfer("pdat", sebs_byte_t'(i * 17), 1'b1);
      u_sebs_bus_master.stop();
      waitProg(1'b1);
      readAt(8'h0e, 8'h11, 8'h22);
      writeAt(8'hff, 8'h3c, 1'b1);
      readAt(8'hff, 8'h3c, 8'h33);
   endtask

   task automatic s_wp();
      pins.wp = 1'b1;
      tick(4);
      writeAt(8'h0e, 8'h99, 1'b0);
      u_sebs_bus_master.start();
      xfer("protWp", dev(`SEBS_TYPE_PROT, 1'b0), 1'b0);
      u_sebs_bus_master.stop();
      pins.wp = 1'b0;
      tick(4);
      readAt(8'h0e, 8'h11, 8'h22);
   endtask

   task automatic s_lock();
      u_sebs_bus_master.start();
      xfer("protR", dev(`SEBS_TYPE_PROT, 1'b1), 1'b1);
      u_sebs_bus_master.stop();
      u_sebs_bus_master.start();
      xfer("prot", dev(`SEBS_TYPE_PROT, 1'b0), 1'b1);
      xfer("dumA", 8'h00, 1'b1);
      xfer("dumD", 8'h00, 1'b1);
      u_sebs_bus_master.stop();
      waitProg(1'b1);
      chk("locked", {7'h0, nvLocked}, 8'h01);
      sys_rst = 1'b1;
      tick(4);
      sys_rst = 1'b0;
      tick(12);
      chk("keep", {7'h0, nvLocked}, 8'h01);
      u_sebs_bus_master.start();
      xfer("prot2", dev(`SEBS_TYPE_PROT, 1'b0), 1'b0);
      u_sebs_bus_master.stop();
      u_sebs_bus_master.start();
      xfer("protR2", dev(`SEBS_TYPE_PROT, 1'b1), 1'b0);
      u_sebs_bus_master.stop();
      writeAt(8'h0f, 8'h55, 1'b0);
      readAt(8'h0e, 8'h11, 8'h22);
      writeAt(8'h80, 8'h66, 1'b1);
      writeAt(8'h81, 8'h67, 1'b1);
      readAt(8'h80, 8'h66, 8'h67);
   endtask

   task automatic s_abort();
      u_sebs_bus_master.start();
      xfer("devW", dev(`SEBS_TYPE_MEM, 1'b0), 1'b1);
      xfer("word", 8'h81, 1'b1);
      u_sebs_bus_master.recover();
      u_sebs_bus_master.stop();
      waitProg(1'b0);
      readAt(8'h80, 8'h66, 8'h67);
   endtask

   initial
   begin
      n_fail = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      pins = '0;
      tick(20);
      sys_rst = 1'b0;
      pins.clr = 1'b1;
      tick(4);
      pins.clr = 1'b0;
      tick(10);
      chk("standby0", {7'h0, standby}, 8'h01);
      chk("lock0", {7'h0, nvLocked}, 8'h00);
      chk("sdaOeN0", {7'h0, sdaOeN}, 8'h01);
      s_decode();
      s_page();
      s_wp();
      s_lock();
      s_abort();
      summarize();
   end

   // Watchdog
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end
endmodule

// ==== verilog/sebs_pkg.sv ====
package sebs_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_DEV    = 3'b001,
      ST_WORD   = 3'b010,
      ST_DATA   = 3'b011,
      ST_SEND   = 3'b100,
      ST_IGNORE = 3'b101
   } sebs_state_e;

   typedef struct packed
   {
      logic scl;
      logic sda;
   } sebs_line_s;

   typedef struct packed
   {
      logic wp;
      logic clr;
      logic [2:0] strap;
   } sebs_pins_s;

   typedef logic [7:0] sebs_byte_t;

endpackage

// ==== verilog/sebs_regs.svh ====
`ifndef SEBS_REGS_SVH
`define SEBS_REGS_SVH

// Slave address type nibbles
`define SEBS_TYPE_MEM      4'ha
`define SEBS_TYPE_PROT     4'h6

// Highest address of the lockable lower half
`define SEBS_LOCK_TOP      8'h7f

// Bit counter positions within one byte frame
`define SEBS_LAST_BIT      4'h7
`define SEBS_ACK_SLOT      4'h8

// Programming cycle time and system clock rate
`define SEBS_PROG_TIME_US  5000
`define SEBS_SYS_CLK_MHZ   20

// Consecutive samples needed to accept a line change
`define SEBS_FILT_LEN      3

`endif

// ==== verilog/sebs_top.sv ====
`timescale 1ns/100ps
`include "sebs_regs.svh"
module sebs_top
   import sebs_pkg::*;
#(
   parameter int unsigned PROG_CYC = `SEBS_PROG_TIME_US * `SEBS_SYS_CLK_MHZ,
   parameter int unsigned FILT_LEN = `SEBS_FILT_LEN
)
(
   // System clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Link sampling clock
   input  wire logic       linkClk,
   // Two-wire bus
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOeN,
   // Straps and protection pins
   input  wire logic       strap_addr_bit0,
   input  wire logic       strap_addr_bit1,
   input  wire logic       strap_addr_bit2,
   input  wire logic       wpIn,
   input  wire logic       nvClear,
   // Status
   output logic            standby,
   output logic            progBusy,
   output logic            nvLocked
);

   localparam int PCW = $clog2(PROG_CYC + 1);

   // Link domain reset
   logic [1:0]   lrst_q;
   logic         linkRst;
   // Line sampling
   sebs_line_s   lineS1_q;
   sebs_line_s   lineS2_q;
   logic [1:0]   rawVec;
   logic [1:0]   filtVec;
   logic         scl;
   logic         sda;
   logic         sclP_q;
   logic         sdaP_q;
   logic         sclRise;
   logic         sclFall;
   logic         startCond;
   logic         stopCond;
   sebs_pins_s   pinS1_q;
   sebs_pins_s   pinS2_q;
   // Protocol engine
   sebs_state_e  state_q;
   sebs_state_e  nextSt_q;
   sebs_state_e  nextSt;
   logic [3:0]   bitCnt_q;
   logic         giveAck;
   logic         lastFall;
   logic         ackFall;
   sebs_byte_t   rxShift_q;
   sebs_byte_t   txShift_q;
   sebs_byte_t   memRd;
   logic         sdaLow_q;
   logic         protCmd_q;
   sebs_byte_t   ptr_q;
   logic         devMatch;
   logic         isMem;
   logic         isProt;
   logic         dataOk;
   // Page buffer and array
   sebs_byte_t   pageBuf [16];
   logic [15:0]  pageMask_q;
   logic [3:0]   pageBase_q;
   logic         protPend_q;
   sebs_byte_t   mem [256];
   logic         nvLock_q;
   logic         standby_q;
   logic         writeAny;
   // Programming handshake
   logic         reqTog_q;
   logic         ackS1_q;
   logic         ackS2_q;
   logic         ackS3_q;
   logic         busyL;
   logic         commitPulse;
   logic         reqS1_q;
   logic         reqS2_q;
   logic         reqS3_q;
   logic         ackTog_q;
   logic         progBusy_q;
   logic [PCW-1:0] progCnt_q;

   // Reset into link domain, released synchronously
   always_ff @(posedge linkClk or posedge sys_rst)
   begin
      if (sys_rst)
         lrst_q <= 2'b11;
      else
         lrst_q <= {lrst_q[0], 1'b0};
   end
   assign linkRst = lrst_q[1];

   // Two-flop synchronisers for bus lines and pins
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         lineS1_q <= '1;
         lineS2_q <= '1;
         pinS1_q  <= '0;
         pinS2_q  <= '0;
      end
      else
      begin
         lineS1_q <= '{scl: sclIn, sda: sdaIn};
         lineS2_q <= lineS1_q;
         pinS1_q  <= '{wp: wpIn, clr: nvClear,
                       strap: {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}};
         pinS2_q  <= pinS1_q;
      end
   end

   assign rawVec = {lineS2_q.scl, lineS2_q.sda};

   // Glitch filter per line
   for (genvar i = 0; i < 2; i++)
   begin : g_filt
      logic [2:0] cnt_q;
      logic       filt_q;
      always_ff @(posedge linkClk or posedge linkRst)
      begin
         if (linkRst)
         begin
            cnt_q  <= 3'h0;
            filt_q <= 1'b1;
         end
         else if (rawVec[i] == filt_q)
            cnt_q <= 3'h0;
         else if (cnt_q == 3'(FILT_LEN - 1))
         begin
            filt_q <= rawVec[i];
            cnt_q  <= 3'h0;
         end
         else
            cnt_q <= cnt_q + 3'h1;
      end
      assign filtVec[i] = filt_q;
   end

   assign scl = filtVec[1];
   assign sda = filtVec[0];

   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end
      else
      begin
         sclP_q <= scl;
         sdaP_q <= sda;
      end
   end

   assign sclRise   = scl & ~sclP_q;
   assign sclFall   = ~scl & sclP_q;
   assign startCond = sclP_q & scl & sdaP_q & ~sda;
   assign stopCond  = sclP_q & scl & ~sdaP_q & sda;
   assign lastFall  = sclFall && (bitCnt_q == `SEBS_LAST_BIT);
   assign ackFall   = sclFall && (bitCnt_q == `SEBS_ACK_SLOT);
   assign busyL     = reqTog_q ^ ackS2_q;
   assign memRd     = mem[ptr_q];
   assign writeAny  = (pageMask_q != 16'h0000) || protPend_q;

   // Byte decode and acknowledge decision
   always_comb
   begin
      devMatch = (rxShift_q[3:1] == pinS2_q.strap);
      isMem    = (rxShift_q[7:4] == `SEBS_TYPE_MEM);
      isProt   = (rxShift_q[7:4] == `SEBS_TYPE_PROT);
      dataOk   = !pinS2_q.wp && !(nvLock_q && (ptr_q <= `SEBS_LOCK_TOP));
      giveAck  = 1'b0;
      nextSt   = ST_IGNORE;
      unique case (state_q)
         ST_DEV:
         begin
            if (!busyL && devMatch)
            begin
               if (isMem)
               begin
                  giveAck = 1'b1;
                  nextSt  = rxShift_q[0] ? ST_SEND : ST_WORD;
               end
               else if (isProt && !nvLock_q && !(pinS2_q.wp && !rxShift_q[0]))
               begin
                  giveAck = 1'b1;
                  nextSt  = rxShift_q[0] ? ST_IGNORE : ST_WORD;
               end
            end
         end
         ST_WORD:
         begin
            giveAck = 1'b1;
            nextSt  = ST_DATA;
         end
         ST_DATA:
         begin
            giveAck = protCmd_q || dataOk;
            nextSt  = ST_DATA;
         end
         ST_SEND:
            nextSt = ST_SEND;
         ST_IDLE, ST_IGNORE:
            nextSt = ST_IGNORE;
         default:
            nextSt = ST_IGNORE;
      endcase
   end

   // Frame state and bit counter
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         state_q  <= ST_IDLE;
         nextSt_q <= ST_IGNORE;
         bitCnt_q <= 4'h0;
      end
      else if (startCond)
      begin
         state_q  <= ST_DEV;
         // Wraps to zero on the clock fall that closes the start
         bitCnt_q <= 4'hf;
      end
      else if (stopCond)
      begin
         state_q  <= ST_IDLE;
         bitCnt_q <= 4'h0;
      end
      else if (state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
         if (lastFall)
         begin
            bitCnt_q <= `SEBS_ACK_SLOT;
            nextSt_q <= (giveAck || state_q == ST_SEND) ? nextSt : ST_IGNORE;
         end
         else if (ackFall)
         begin
            bitCnt_q <= 4'h0;
            state_q  <= nextSt_q;
         end
         else if (sclFall)
            bitCnt_q <= bitCnt_q + 4'h1;
         if (sclRise && state_q == ST_SEND && bitCnt_q == `SEBS_ACK_SLOT && sda)
            nextSt_q <= ST_IGNORE;
      end
   end

   // Receive shift register
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
         rxShift_q <= 8'h00;
      else if (sclRise && bitCnt_q != `SEBS_ACK_SLOT)
         rxShift_q <= {rxShift_q[6:0], sda};
   end

   // Open-drain data drive and transmit shifter
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         sdaLow_q  <= 1'b0;
         txShift_q <= 8'h00;
      end
      else if (startCond || stopCond)
         sdaLow_q <= 1'b0;
      else if (lastFall)
         sdaLow_q <= giveAck && state_q != ST_SEND;
      else if (ackFall)
      begin
         if (nextSt_q == ST_SEND && state_q != ST_IDLE && state_q != ST_IGNORE)
         begin
            txShift_q <= memRd;
            sdaLow_q  <= ~memRd[7];
         end
         else
            sdaLow_q <= 1'b0;
      end
      else if (sclFall && state_q == ST_SEND)
      begin
         txShift_q <= {txShift_q[6:0], 1'b0};
         sdaLow_q  <= ~txShift_q[6];
      end
   end

   // Protection command flag
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
         protCmd_q <= 1'b0;
      else if (startCond)
         protCmd_q <= 1'b0;
      else if (lastFall && state_q == ST_DEV && giveAck)
         protCmd_q <= isProt;
   end

   // Address pointer
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
         ptr_q <= 8'h00;
      else if (lastFall && state_q == ST_WORD && !protCmd_q)
         ptr_q <= rxShift_q;
      else if (lastFall && state_q == ST_DATA && giveAck && !protCmd_q)
         ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
      else if (ackFall && state_q == ST_SEND && nextSt_q == ST_SEND)
         ptr_q <= ptr_q + 8'h01;
      else if (ackFall && state_q == ST_DEV && nextSt_q == ST_SEND)
         ptr_q <= ptr_q + 8'h01;
   end

   // Page buffer and pending protection
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         pageMask_q <= 16'h0000;
         pageBase_q <= 4'h0;
         protPend_q <= 1'b0;
      end
      else if (commitPulse || (startCond && !busyL))
      begin
         pageMask_q <= 16'h0000;
         protPend_q <= 1'b0;
      end
      else if (lastFall && state_q == ST_DATA && giveAck)
      begin
         if (protCmd_q)
            protPend_q <= 1'b1;
         else
         begin
            pageMask_q[ptr_q[3:0]] <= 1'b1;
            pageBase_q <= ptr_q[7:4];
         end
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (lastFall && state_q == ST_DATA && giveAck && !protCmd_q)
         pageBuf[ptr_q[3:0]] <= rxShift_q;
   end

   // Array commit when programming completes
   always_ff @(posedge linkClk)
   begin
      if (commitPulse)
      begin
         for (int k = 0; k < 16; k++)
         begin
            if (pageMask_q[k])
               mem[{pageBase_q, 4'(k)}] <= pageBuf[k];
         end
      end
   end

   // Nonvolatile lock, untouched by reset
   always_ff @(posedge linkClk)
   begin
      if (pinS2_q.clr)
         nvLock_q <= 1'b0;
      else if (commitPulse && protPend_q)
         nvLock_q <= 1'b1;
   end

   // Programming request toggle
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
         reqTog_q <= 1'b0;
      else if (stopCond && writeAny && !busyL)
         reqTog_q <= ~reqTog_q;
   end

   // Completion toggle back into link domain
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
      begin
         ackS1_q <= 1'b0;
         ackS2_q <= 1'b0;
         ackS3_q <= 1'b0;
      end
      else
      begin
         ackS1_q <= ackTog_q;
         ackS2_q <= ackS1_q;
         ackS3_q <= ackS2_q;
      end
   end
   assign commitPulse = ackS2_q ^ ackS3_q;

   // Standby tracking
   always_ff @(posedge linkClk or posedge linkRst)
   begin
      if (linkRst)
         standby_q <= 1'b1;
      else if (commitPulse)
         standby_q <= 1'b1;
      else if (stopCond && !writeAny)
         standby_q <= 1'b1;
      else if (scl != sclP_q || sda != sdaP_q)
         standby_q <= 1'b0;
   end

   // Request toggle into system domain
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reqS1_q <= 1'b0;
         reqS2_q <= 1'b0;
         reqS3_q <= 1'b0;
      end
      else
      begin
         reqS1_q <= reqTog_q;
         reqS2_q <= reqS1_q;
         reqS3_q <= reqS2_q;
      end
   end

   // Self-timed programming cycle
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         progBusy_q <= 1'b0;
         progCnt_q  <= '0;
         ackTog_q   <= 1'b0;
      end
      else if (reqS2_q ^ reqS3_q)
      begin
         progBusy_q <= 1'b1;
         progCnt_q  <= PCW'(PROG_CYC - 1);
      end
      else if (progBusy_q)
      begin
         if (progCnt_q == '0)
         begin
            progBusy_q <= 1'b0;
            ackTog_q   <= ~ackTog_q;
         end
         else
            progCnt_q <= progCnt_q - PCW'(1);
      end
   end

   assign sdaOut   = 1'b0;
   assign sdaOeN   = ~sdaLow_q;
   assign standby  = standby_q;
   assign progBusy = progBusy_q;
   assign nvLocked = nvLock_q;

endmodule
